// ---- hw/tt_regs.svh ----
`ifndef TT_REGS_SVH
`define TT_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TT_ADDR_LOW_BITS 8'h77
`define TT_ADDR_CONFIG3 8'h78
`define TT_ADDR_DURATION 8'h79

// ----------------------------------------
// reset values and unmapped read value
// ----------------------------------------
`define TT_CONFIG3_RESET 8'h00
`define TT_DURATION_RESET 8'h00
`define TT_READ_ZERO 8'h00

// ----------------------------------------
// config3 field positions
// ----------------------------------------
`define TT_CFG_ALERT 0
`define TT_CFG_OVERTEMP_EN 1
`define TT_CFG_BOOST 2
`define TT_CFG_FAST 3
`define TT_CFG_DC1 4
`define TT_CFG_DC2 5
`define TT_CFG_DC3 6
`define TT_CFG_DC4 7

// ----------------------------------------
// alternate pin function code for overtemp use (arbitrary)
// ----------------------------------------
`define TT_ALT_FUNC_OVERTEMP 2'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define TT_CLK_HZ 25000000
`define TT_STEP_US 22760
`define TT_THRESHOLD_US 45520
`define TT_COUNT_MAX 8'hFF
`define TT_SENSE_SLOW_MS 1000
`define TT_SENSE_FAST_MS 250

`endif

// ---- hw/tt_pkg.sv ----
package tt_pkg;
   typedef logic [7:0] tt_byte_t;
   typedef logic [1:0] tt_low_bits_t;
   typedef enum logic [1:0] {
      TT_IDLE = 2'b01,
      TT_TIMING = 2'b10
   } tt_timer_state_t;
endpackage : tt_pkg

// ---- hw/tt_sync.sv ----
`timescale 1ns/100ps
module tt_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;
   logic next_stage1;
   logic next_sync_out;

   always_comb begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   // inactive level of a low-active pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule : tt_sync

// ---- hw/tt_thermal_timer_config_regs.sv ----
`timescale 1ns/100ps
`include "tt_regs.svh"
module tt_thermal_timer_config_regs #(
   parameter int STEP_CYCLES = (`TT_CLK_HZ / 1000000) * `TT_STEP_US,
   parameter int SENSE_SLOW_CYCLES = (`TT_CLK_HZ / 1000) * `TT_SENSE_SLOW_MS,
   parameter int SENSE_FAST_CYCLES = (`TT_CLK_HZ / 1000) * `TT_SENSE_FAST_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire tt_pkg::tt_byte_t reg_wdata,
   output tt_pkg::tt_byte_t reg_rdata,
   output logic reg_rvalid,
   input wire logic global_lock,
   input wire tt_pkg::tt_low_bits_t supply_12v_low_bits,
   input wire tt_pkg::tt_low_bits_t remote1_temp_low_bits,
   input wire tt_pkg::tt_low_bits_t local_temp_low_bits,
   input wire tt_pkg::tt_low_bits_t remote2_temp_low_bits,
   input wire logic [3:0] msb_read,
   output logic [3:0] msb_frozen,
   input wire logic overtemp_pin_n,
   input wire logic overtemp_pin_is_input,
   input wire logic alt_pin_n,
   input wire logic [1:0] alt_pin_function_select,
   output tt_pkg::tt_byte_t config3_value,
   output logic alert_pin_mode,
   output logic fan_drive_output_2_select,
   output logic overtemp_enable,
   output logic fan_boost_force,
   output logic fan_speed_sense_tick,
   output logic continuous_sense_ch1,
   output logic continuous_sense_ch2,
   output logic continuous_sense_ch3,
   output logic continuous_sense_ch4,
   output logic [3:0] pulse_stretch_enable
);
   import tt_pkg::*;

   localparam int THRESHOLD_STEPS = `TT_THRESHOLD_US / `TT_STEP_US;
   localparam logic [7:0] THRESHOLD = 8'(THRESHOLD_STEPS);
   localparam logic [19:0] STEP_LAST = 20'(STEP_CYCLES - 1);
   localparam logic [24:0] SLOW_LAST = 25'(SENSE_SLOW_CYCLES - 1);
   localparam logic [24:0] FAST_LAST = 25'(SENSE_FAST_CYCLES - 1);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic pin_s_n;
   logic alt_s_n;
   tt_sync u_sync_pin (.clk(clk), .rst_n(rst_n), .async_in(overtemp_pin_n), .sync_out(pin_s_n));
   tt_sync u_sync_alt (.clk(clk), .rst_n(rst_n), .async_in(alt_pin_n), .sync_out(alt_s_n));

   // ----------------------------------------
   // decode
   // ----------------------------------------
   tt_byte_t cfg;
   logic rd_low;
   logic rd_cfg;
   logic rd_dur;
   logic wr_cfg;
   logic overtemp_asserted;
   assign rd_low = reg_rd && (reg_addr == `TT_ADDR_LOW_BITS);
   assign rd_cfg = reg_rd && (reg_addr == `TT_ADDR_CONFIG3);
   assign rd_dur = reg_rd && (reg_addr == `TT_ADDR_DURATION);
   assign wr_cfg = reg_wr && (reg_addr == `TT_ADDR_CONFIG3);
   assign overtemp_asserted = cfg[`TT_CFG_OVERTEMP_EN] && (!pin_s_n ||
      ((alt_pin_function_select == `TT_ALT_FUNC_OVERTEMP) && !alt_s_n));

   // ----------------------------------------
   // config register
   // ----------------------------------------
   tt_byte_t next_cfg;
   always_comb begin
      next_cfg = cfg;
      if (wr_cfg && !global_lock) begin
         next_cfg = reg_wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= `TT_CONFIG3_RESET;
      end else begin
         cfg <= next_cfg;
      end
   end
   assign config3_value = cfg;
   assign alert_pin_mode = cfg[`TT_CFG_ALERT];
   assign fan_drive_output_2_select = !cfg[`TT_CFG_ALERT];
   assign overtemp_enable = cfg[`TT_CFG_OVERTEMP_EN];
   assign fan_boost_force = overtemp_asserted && overtemp_pin_is_input && cfg[`TT_CFG_BOOST];
   assign continuous_sense_ch1 = cfg[`TT_CFG_DC1];
   assign continuous_sense_ch2 = cfg[`TT_CFG_DC2];
   assign continuous_sense_ch3 = cfg[`TT_CFG_DC3];
   assign continuous_sense_ch4 = cfg[`TT_CFG_DC4];
   assign pulse_stretch_enable = ~cfg[`TT_CFG_DC4:`TT_CFG_DC1];

   // ----------------------------------------
   // speed-sense rate divider
   // ----------------------------------------
   logic [24:0] sense_cnt;
   logic [24:0] next_sense_cnt;
   logic next_sense_tick;
   always_comb begin
      next_sense_cnt = sense_cnt + 25'h0000001;
      next_sense_tick = 1'b0;
      if (sense_cnt >= (cfg[`TT_CFG_FAST] ? FAST_LAST : SLOW_LAST)) begin
         next_sense_cnt = 25'h0000000;
         next_sense_tick = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_cnt <= 25'h0000000;
         fan_speed_sense_tick <= 1'b0;
      end else begin
         sense_cnt <= next_sense_cnt;
         fan_speed_sense_tick <= next_sense_tick;
      end
   end

   // ----------------------------------------
   // low bits and freeze
   // ----------------------------------------
   tt_byte_t live_low;
   tt_byte_t low_view;
   tt_byte_t low_snap;
   tt_byte_t next_low_snap;
   logic low_frozen;
   logic next_low_frozen;
   logic [3:0] next_msb_frozen;
   assign live_low = {remote2_temp_low_bits, local_temp_low_bits,
                      remote1_temp_low_bits, supply_12v_low_bits};
   assign low_view = low_frozen ? low_snap : live_low;
   always_comb begin
      next_low_snap = low_view;
      next_msb_frozen = msb_frozen & ~msb_read;
      next_low_frozen = low_frozen && (next_msb_frozen != 4'h0);
      if (rd_low) begin
         next_msb_frozen = 4'hF;
         next_low_frozen = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_snap <= 8'h00;
         low_frozen <= 1'b0;
         msb_frozen <= 4'h0;
      end else begin
         low_snap <= next_low_snap;
         low_frozen <= next_low_frozen;
         msb_frozen <= next_msb_frozen;
      end
   end

   // ----------------------------------------
   // overtemp duration timer
   // ----------------------------------------
   tt_timer_state_t state;
   tt_timer_state_t next_state;
   logic [19:0] step_cnt;
   logic [19:0] next_step_cnt;
   tt_byte_t dur_cnt;
   tt_byte_t next_dur_cnt;
   logic asserted_flag;
   logic next_asserted_flag;
   tt_byte_t dur_view;
   always_comb begin
      next_state = state;
      next_step_cnt = step_cnt;
      next_dur_cnt = dur_cnt;
      next_asserted_flag = (asserted_flag && !rd_dur) || overtemp_asserted;
      unique case (state)
         TT_IDLE: begin
            if (rd_dur) begin
               next_dur_cnt = `TT_DURATION_RESET;
            end
            if (overtemp_asserted && !cfg[`TT_CFG_BOOST]) begin
               next_state = TT_TIMING;
               next_step_cnt = 20'h00000;
               next_dur_cnt = `TT_DURATION_RESET;
            end
         end
         TT_TIMING: begin
            if (!overtemp_asserted) begin
               next_state = TT_IDLE;
            end else if (step_cnt == STEP_LAST) begin
               next_step_cnt = 20'h00000;
               if (dur_cnt != `TT_COUNT_MAX) begin
                  next_dur_cnt = dur_cnt + 8'h01;
               end
            end else begin
               next_step_cnt = step_cnt + 20'h00001;
            end
         end
         default: next_state = TT_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= TT_IDLE;
         step_cnt <= 20'h00000;
         dur_cnt <= `TT_DURATION_RESET;
         asserted_flag <= 1'b0;
      end else begin
         state <= next_state;
         step_cnt <= next_step_cnt;
         dur_cnt <= next_dur_cnt;
         asserted_flag <= next_asserted_flag;
      end
   end
   assign dur_view = (dur_cnt >= THRESHOLD) ? dur_cnt : {7'h00, asserted_flag};

   // ----------------------------------------
   // read port
   // ----------------------------------------
   tt_byte_t next_rdata;
   logic next_rvalid;
   always_comb begin
      next_rdata = reg_rdata;
      next_rvalid = rd_low || rd_cfg || rd_dur;
      if (rd_low) begin
         next_rdata = low_view;
      end else if (rd_cfg) begin
         next_rdata = cfg;
      end else if (rd_dur) begin
         next_rdata = dur_view;
      end else if (reg_rd) begin
         next_rdata = `TT_READ_ZERO;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_low_bits_layout: assert property (@(posedge clk) disable iff (!rst_n)
      rd_low && !low_frozen |=> reg_rdata == {$past(remote2_temp_low_bits), $past(local_temp_low_bits),
      $past(remote1_temp_low_bits), $past(supply_12v_low_bits)}) else $error("low bits layout wrong");
   a_low_upper_pairs: assert property (@(posedge clk) disable iff (!rst_n)
      rd_low && !low_frozen |=> reg_rdata[7:4] == $past(live_low[7:4])) else $error("upper low bits wrong");
   a_freeze_all: assert property (@(posedge clk) disable iff (!rst_n)
      rd_low |=> msb_frozen == 4'hF && low_frozen ##1 low_snap == $past(low_snap) || !low_frozen)
      else $error("freeze not taken");
   a_alert_mode_map: assert property (@(posedge clk) disable iff (!rst_n)
      alert_pin_mode != fan_drive_output_2_select && alert_pin_mode == config3_value[0])
      else $error("shared pin mode wrong");
   a_boost_gate: assert property (@(posedge clk) disable iff (!rst_n)
      fan_boost_force |-> config3_value[2] && config3_value[1] && overtemp_pin_is_input)
      else $error("boost without cause");
   a_dc_map: assert property (@(posedge clk) disable iff (!rst_n)
      {continuous_sense_ch4, continuous_sense_ch3, continuous_sense_ch2, continuous_sense_ch1}
      == ~pulse_stretch_enable) else $error("continuous sense map wrong");
   a_lock_ignore: assert property (@(posedge clk) disable iff (!rst_n)
      global_lock |=> $stable(config3_value)) else $error("locked config changed");
   a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_cfg && !global_lock |=> config3_value == $past(reg_wdata)) else $error("config write lost");
   a_dur_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rd_dur && dur_cnt < THRESHOLD |=> reg_rdata[7:1] == 7'h00) else $error("duration high bits early");
   a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      overtemp_asserted |=> asserted_flag) else $error("assertion flag lost");
   a_flag_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
      rd_dur && !overtemp_asserted |=> !asserted_flag) else $error("flag not cleared by read");
   a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
      state == TT_TIMING && overtemp_asserted && step_cnt == STEP_LAST && dur_cnt != 8'hFF
      |=> dur_cnt == $past(dur_cnt) + 8'h01) else $error("duration step missed");
endmodule : tt_thermal_timer_config_regs

// ---- bench/tt_host_model.sv ----
`timescale 1ns/100ps
module tt_host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output tt_pkg::tt_byte_t reg_wdata,
   output logic [3:0] msb_read,
   input wire tt_pkg::tt_byte_t reg_rdata,
   input wire logic reg_rvalid
);
   import tt_pkg::*;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      msb_read = 4'h0;
   end
   // ----------------------------------------
   // one strobe cycle then one idle cycle
   // ----------------------------------------
   task automatic xfer(input logic [7:0] addr, input logic wr, input logic rd, input tt_byte_t wdata,
         input logic [3:0] msb, output tt_byte_t rdata, output logic rvalid);
      reg_addr = addr;
      reg_wr = wr;
      reg_rd = rd;
      reg_wdata = wdata;
      msb_read = msb;
      @(posedge clk);
      #1;
      rdata = reg_rdata;
      rvalid = reg_rvalid;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      msb_read = 4'h0;
      // released lines show the inverse
      reg_addr = ~addr;
      reg_wdata = ~wdata;
      @(posedge clk);
      #1;
   endtask : xfer
endmodule : tt_host_model

// ---- bench/tb_thermal_timer_config_regs.sv ----
`timescale 1ns/100ps
`include "tt_regs.svh"
module tb_thermal_timer_config_regs;
   import tt_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr;
   logic reg_wr, reg_rd, reg_rvalid, global_lock, overtemp_pin_n, overtemp_pin_is_input, alt_pin_n;
   tt_byte_t reg_wdata, reg_rdata, config3_value;
   tt_low_bits_t supply_12v_low_bits, remote1_temp_low_bits, local_temp_low_bits, remote2_temp_low_bits;
   logic [3:0] msb_read, msb_frozen, pulse_stretch_enable;
   logic [1:0] alt_pin_function_select;
   logic alert_pin_mode, fan_drive_output_2_select, overtemp_enable, fan_boost_force, fan_speed_sense_tick;
   logic continuous_sense_ch1, continuous_sense_ch2, continuous_sense_ch3, continuous_sense_ch4;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   tt_byte_t d;
   logic v;
   always #20 clk = ~clk;
   tt_thermal_timer_config_regs #(.STEP_CYCLES(8), .SENSE_SLOW_CYCLES(16), .SENSE_FAST_CYCLES(4)) i_dut (
      .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .global_lock,
      .supply_12v_low_bits, .remote1_temp_low_bits, .local_temp_low_bits, .remote2_temp_low_bits,
      .msb_read, .msb_frozen, .overtemp_pin_n, .overtemp_pin_is_input, .alt_pin_n, .alt_pin_function_select,
      .config3_value, .alert_pin_mode, .fan_drive_output_2_select, .overtemp_enable, .fan_boost_force,
      .fan_speed_sense_tick, .continuous_sense_ch1, .continuous_sense_ch2, .continuous_sense_ch3,
      .continuous_sense_ch4, .pulse_stretch_enable);
   tt_host_model i_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .msb_read, .reg_rdata, .reg_rvalid);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check_byte(input tt_byte_t got, input tt_byte_t exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input tt_byte_t w);
      i_host.xfer(a, 1'b1, 1'b0, w, 4'h0, d, v);
   endtask : wr
   task automatic rd(input logic [7:0] a, input tt_byte_t exp);
      i_host.xfer(a, 1'b0, 1'b1, 8'h00, 4'h0, d, v);
      check_byte(d, exp);
      check_byte({7'h00, v}, 8'h01);
   endtask : rd
   task automatic tick_gap(input tt_byte_t exp);
      int n;
      n = 0;
      while (fan_speed_sense_tick !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (fan_speed_sense_tick !== 1'b1 && n < 40);
      check_byte(8'(n), exp);
   endtask : tick_gap
   task automatic pin_pulse(input int n, input tt_byte_t exp);
      overtemp_pin_n = 1'b0;
      cyc(n);
      overtemp_pin_n = 1'b1;
      cyc(6);
      rd(`TT_ADDR_DURATION, exp);
   endtask : pin_pulse
   task automatic end_of_test();
      $display("samples_checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check_byte(config3_value, 8'h00);
      check_byte({3'h0, fan_drive_output_2_select, pulse_stretch_enable}, 8'h1F);
      rd(`TT_ADDR_CONFIG3, 8'h00);
      rd(`TT_ADDR_DURATION, 8'h00);
      i_host.xfer(8'h10, 1'b0, 1'b1, 8'h00, 4'h0, d, v);
      check_byte({d[7:1], v}, 8'h00);
   endtask : t_reset
   task automatic t_config();
      tt_byte_t c;
      for (int i = 0; i < 8; i++) begin
         c = 8'h01 << i;
         wr(`TT_ADDR_CONFIG3, c);
         rd(`TT_ADDR_CONFIG3, c);
         check_byte({continuous_sense_ch4, continuous_sense_ch3, continuous_sense_ch2, continuous_sense_ch1,
            1'b0, overtemp_enable, fan_drive_output_2_select, alert_pin_mode},
            {c[7:4], 1'b0, c[1], ~c[0], c[0]});
         check_byte({4'h0, pulse_stretch_enable}, {4'h0, ~c[7:4]});
      end
   endtask : t_config
   task automatic t_lock();
      global_lock = 1'b1;
      wr(`TT_ADDR_CONFIG3, 8'hFF);
      rd(`TT_ADDR_CONFIG3, 8'h80);
      global_lock = 1'b0;
      wr(`TT_ADDR_DURATION, 8'hFF);
      rd(`TT_ADDR_DURATION, 8'h00);
      wr(`TT_ADDR_CONFIG3, 8'h00);
      rd(`TT_ADDR_CONFIG3, 8'h00);
   endtask : t_lock
   task automatic t_low_bits();
      {remote2_temp_low_bits, local_temp_low_bits, remote1_temp_low_bits, supply_12v_low_bits} = 8'h39;
      rd(`TT_ADDR_LOW_BITS, 8'h39);
      check_byte({4'h0, msb_frozen}, 8'h0F);
      {remote2_temp_low_bits, local_temp_low_bits, remote1_temp_low_bits, supply_12v_low_bits} = 8'hC6;
      rd(`TT_ADDR_LOW_BITS, 8'h39);
      check_byte({4'h0, msb_frozen}, 8'h0F);
      for (int i = 0; i < 4; i++) begin
         i_host.xfer(8'h00, 1'b0, 1'b0, 8'h00, 4'h1 << i, d, v);
         check_byte({4'h0, msb_frozen}, {4'h0, 4'hF << (i + 1)});
      end
      rd(`TT_ADDR_LOW_BITS, 8'hC6);
      i_host.xfer(8'h00, 1'b0, 1'b0, 8'h00, 4'hF, d, v);
   endtask : t_low_bits
   task automatic t_sense();
      tick_gap(8'h10);
      wr(`TT_ADDR_CONFIG3, 8'h08);
      tick_gap(8'h04);
   endtask : t_sense
   task automatic t_timer();
      wr(`TT_ADDR_CONFIG3, 8'h02);
      pin_pulse(5, 8'h01);
      rd(`TT_ADDR_DURATION, 8'h00);
      pin_pulse(28, 8'h03);
      rd(`TT_ADDR_DURATION, 8'h00);
      pin_pulse(2100, 8'hFF);
      rd(`TT_ADDR_DURATION, 8'h00);
   endtask : t_timer
   task automatic t_boost();
      wr(`TT_ADDR_CONFIG3, 8'h06);
      overtemp_pin_n = 1'b0;
      cyc(4);
      check_byte({7'h00, fan_boost_force}, 8'h01);
      overtemp_pin_is_input = 1'b0;
      cyc(1);
      check_byte({7'h00, fan_boost_force}, 8'h00);
      overtemp_pin_is_input = 1'b1;
      pin_pulse(24, 8'h01);
      check_byte({7'h00, fan_boost_force}, 8'h00);
      alt_pin_function_select = `TT_ALT_FUNC_OVERTEMP;
      alt_pin_n = 1'b0;
      cyc(4);
      check_byte({7'h00, fan_boost_force}, 8'h01);
      alt_pin_function_select = 2'h2;
      cyc(2);
      check_byte({7'h00, fan_boost_force}, 8'h00);
      alt_pin_n = 1'b1;
      wr(`TT_ADDR_CONFIG3, 8'h04);
      overtemp_pin_n = 1'b0;
      cyc(4);
      check_byte({7'h00, fan_boost_force}, 8'h00);
      overtemp_pin_n = 1'b1;
   endtask : t_boost
   // ----------------------------------------
   // main sequence and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      global_lock = 1'b0;
      overtemp_pin_n = 1'b1;
      overtemp_pin_is_input = 1'b1;
      alt_pin_n = 1'b1;
      alt_pin_function_select = 2'h0;
      {remote2_temp_low_bits, local_temp_low_bits, remote1_temp_low_bits, supply_12v_low_bits} = 8'h00;
      cyc(10);
      rst_n = 1'b1;
      t_reset();
      t_config();
      t_lock();
      t_low_bits();
      t_sense();
      t_timer();
      t_boost();
      end_of_test();
   end
endmodule : tb_thermal_timer_config_regs
